/* File: dv/flash_device_model.sv */
// flash bank model: unlock decode, busy timer, status bits
// assumes clock-synchronous pins from the host
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module flash_device_model
	import flash_host_pkg::*;
#(
	parameter int BUSY_CYC = 300,
	parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
	parameter logic [7:0] PART_ID = 8'h4D // arbitrary value
) (
	input wire logic clock,
	input wire flash_pins_t pins,
	output logic [7:0] dq_in = 8'h00
);
	localparam logic [25:0] U0 = {`UNL_ADDR0, `UNL_DATA0};
	localparam logic [25:0] U1 = {`UNL_ADDR1, `UNL_DATA1};
	logic [7:0] mem [int];
	logic [25:0] w [0:5];
	int busy = 0;
	logic id_mode = 0, tog = 0, erasing = 0, ws_q = 1, gate_q = 1;
	logic [7:0] pdat = 8'h00;
	logic [17:0] a;
	always @(posedge clock) begin
		ws_q <= pins.write_strobe_n;
		gate_q <= pins.output_gate_n;
		if (busy > 0) busy <= busy - 1;
		if (pins.output_gate_n && !gate_q && busy > 0) tog <= ~tog;
		if (!pins.write_strobe_n && ws_q) a = pins.addr;
		// one-cycle strobes are the shortest seen; 5 ns glitches never reach here
		if (pins.write_strobe_n && !ws_q && !pins.flash_bank_select_n && pins.output_gate_n
			&& busy == 0) begin
			for (int i = 5; i > 0; i--) w[i] = w[i-1];
			w[0] = {a, pins.dq_out}; // a wrong byte in w[1] or w[2] breaks every pattern below; program data in w[0] is taken as is
			if (w[3] == U0 && w[2] == U1 && w[1] == {`UNL_ADDR0, `CODE_PROGRAM}) begin
				pdat = w[0][7:0];
				mem[w[0][25:8]] = (mem.exists(w[0][25:8]) ? mem[w[0][25:8]] : 8'hFF) & pdat;
				busy <= BUSY_CYC;
				erasing <= 0;
				w = '{default: '0};
			end else if (w[2] == U0 && w[1] == U1 && w[0][7:0] == `CODE_ID_ENTRY) begin
				id_mode <= 1;
				w = '{default: '0};
			end else if (w[2] == U0 && w[1] == U1 && w[0][7:0] == `CODE_ID_EXIT) begin
				id_mode <= 0;
				w = '{default: '0};
			end else if (w[5] == U0 && w[4] == U1 && w[3] == {`UNL_ADDR0, `CODE_ERASE_SETUP}
				&& w[2] == U0 && w[1] == U1) begin
				if (w[0][7:0] == `CODE_SECTOR) begin
					foreach (mem[k]) if (k[17:12] == w[0][25:20]) mem[k] = 8'hFF;
				end else if (w[0] == {`BANK_ADDR, `CODE_BANK}) mem.delete();
				busy <= 2 * BUSY_CYC;
				erasing <= 1;
				w = '{default: '0};
			end
		end
		// released bus shows a changing pattern, never the last value
		if (pins.flash_bank_select_n || pins.output_gate_n) dq_in <= ~dq_in;
		else if (busy > 0) dq_in <= {erasing ? 1'b0 : ~pdat[7], tog, 6'h2A};
		else if (id_mode) dq_in <= pins.addr[0] ? PART_ID : MAKER_ID;
		else dq_in <= mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
	end
endmodule : flash_device_model

/* File: dv/flash_host_ctrl_properties.sv */
// checker: pin and request timing of the flash host
// assumes the bind below onto flash_host_ctrl
`timescale 1ns/1ps
module flash_host_ctrl_properties
	import flash_host_pkg::*;
#(
	parameter logic [31:0] ERASE_TIMEOUT_CYC = 32'h0BEB_C200
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire req_t req,
	input wire logic req_ready,
	input wire logic rsp_done,
	input wire rsp_t rsp,
	input wire flash_pins_t pins,
	input wire logic [7:0] dq_in
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence take_read;
		req_valid && req_ready && req.op == OP_READ;
	endsequence
	sequence strobe_pulse;
		(!pins.write_strobe_n)[*4] ##1 pins.write_strobe_n;
	endsequence
	strobe_qual_a: assert property (!pins.write_strobe_n |-> !pins.flash_bank_select_n
		&& pins.output_gate_n && !pins.dq_oe_n) else $error("strobe low unqualified");
	sram_off_a: assert property (pins.sram_bank_select_n)
		else $error("sram select driven");
	strobe_width_a: assert property ($fell(pins.write_strobe_n) |-> strobe_pulse)
		else $error("strobe pulse width wrong");
	addr_hold_a: assert property (!pins.write_strobe_n && $past(!pins.write_strobe_n)
		|-> $stable(pins.addr) && $stable(pins.dq_out)) else $error("addr moved in strobe");
	data_hold_a: assert property ($rose(pins.write_strobe_n) |-> $stable(pins.dq_out)
		&& !pins.flash_bank_select_n) else $error("data not held at strobe rise");
	read_gate_a: assert property (!pins.output_gate_n |-> pins.dq_oe_n
		&& pins.write_strobe_n) else $error("read while driving");
	read_time_a: assert property (take_read |-> ##20 rsp_done)
		else $error("read answer late");
	take_busy_a: assert property (req_valid && req_ready |=> !req_ready && !rsp_done)
		else $error("ready after take");
	done_pulse_a: assert property (rsp_done |-> req_ready ##1 !rsp_done)
		else $error("done not a pulse");
endmodule : flash_host_ctrl_properties

bind flash_host_ctrl flash_host_ctrl_properties #(.ERASE_TIMEOUT_CYC(ERASE_TIMEOUT_CYC)) props (
	.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
	.rsp_done(rsp_done), .rsp(rsp), .pins(pins), .dq_in(dq_in));

/* File: dv/test_flash_program_erase_sequencer.sv */
// bench: program, erase and id flows against the device model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module test_flash_program_erase_sequencer import flash_host_pkg::*;;
	localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
	localparam logic [7:0] PART = 8'h4D; // arbitrary value
	logic clock = 0, rst_n = 0, req_valid = 0, req_ready, rsp_done;
	req_t req = '0;
	rsp_t rsp;
	flash_pins_t pins;
	logic [7:0] dq_in;
	int fail_count = 0, n_compared = 0;
	always #2.5 clock = ~clock;
	// short erase timeout keeps the run brief
	flash_host_ctrl #(.ERASE_TIMEOUT_CYC(32'h0000_1388)) dut (.clock(clock), .rst_n(rst_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_done(rsp_done),
		.rsp(rsp), .pins(pins), .dq_in(dq_in));
	flash_device_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (.clock(clock), .pins(pins),
		.dq_in(dq_in));
	task end_of_test;
		if (fail_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task chk_flag(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : chk_flag
	task run(input op_t op, input logic [17:0] ad, input logic [7:0] d);
		int i;
		@(posedge clock);
		#1 req_valid = 1;
		req = '{op, ad, d};
		@(posedge clock);
		#1 req_valid = 0;
		for (i = 0; i < 20000 && rsp_done !== 1'b1; i++) @(posedge clock) #1;
		if (rsp_done !== 1'b1) begin
			fail_count++;
			end_of_test();
		end
		chk_flag(rsp.err, 1'b0);
	endtask : run
	task t_program;
		run(OP_READ, 18'h0_1234, 8'h00);
		chk(rsp.rdata, 8'hFF);
		run(OP_PROGRAM, 18'h0_1234, 8'h5C);
		chk(rsp.rdata, 8'h5C);
		run(OP_PROGRAM, 18'h3_FFFF, 8'h00);
		chk(rsp.rdata, 8'h00);
		run(OP_READ, 18'h0_1234, 8'h00);
		chk(rsp.rdata, 8'h5C);
	endtask : t_program
	task t_erase;
		run(OP_SECTOR_ERASE, 18'h0_1234, 8'h00);
		chk_flag(rsp.rdata[7], 1'b1);
		run(OP_READ, 18'h0_1234, 8'h00);
		chk(rsp.rdata, 8'hFF);
		run(OP_READ, 18'h3_FFFF, 8'h00);
		chk(rsp.rdata, 8'h00);
		run(OP_BANK_ERASE, 18'h0_0000, 8'h00);
		chk_flag(rsp.rdata[7], 1'b1);
		run(OP_READ, 18'h3_FFFF, 8'h00);
		chk(rsp.rdata, 8'hFF);
	endtask : t_erase
	task t_ident;
		run(OP_ID_ENTRY, 18'h0_0000, 8'h00);
		run(OP_READ, 18'h0_0000, 8'h00);
		chk(rsp.rdata, MAKER);
		run(OP_READ, 18'h0_0001, 8'h00);
		chk(rsp.rdata, PART);
		run(OP_ID_EXIT, 18'h0_0000, 8'h00);
		run(OP_READ, 18'h0_0001, 8'h00);
		chk(rsp.rdata, 8'hFF);
	endtask : t_ident
	initial begin
		repeat (6) @(posedge clock);
		#1 rst_n = 1;
		chk_flag(pins.write_strobe_n, 1'b1);
		t_program();
		t_erase();
		t_ident();
		end_of_test();
	end
endmodule : test_flash_program_erase_sequencer

/* File: rtl/flash_host_consts.svh */
// flash_host_consts.svh: timing counts, command codes and unlock words for the flash host.
// assumes a 200 MHz clock and an 18-bit flash address space.
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

`define CLK_MHZ 200
// write strobe low time; well above the 5 ns glitch filter
`define WE_LOW_NS 20
`define WE_LOW_CYC ((`WE_LOW_NS * `CLK_MHZ + 999) / 1000)
// read access wait before sampling the data pins
`define RD_NS 80
`define RD_CYC ((`RD_NS * `CLK_MHZ + 999) / 1000)
// longest program time; longest figure, exact in cycles with no rounding
`define PROG_MAX_US 20
`define PROG_MAX_CYC (`PROG_MAX_US * `CLK_MHZ)
// wait for the whole data bus to be valid after program ends
`define SETTLE_US 1
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
// polls needed: first read plus two agreeing rereads
`define STABLE_NEED 2'h2

// unlock words, checked in order by the device
`define UNL_ADDR0 18'h0_5555
`define UNL_DATA0 8'hA5
`define UNL_ADDR1 18'h0_2AAA
`define UNL_DATA1 8'h5A
`define CODE_PROGRAM 8'h0A
`define CODE_ERASE_SETUP 8'h08
`define CODE_ID_ENTRY 8'h09
`define CODE_ID_EXIT 8'h0F
`define CODE_SECTOR 8'h30
`define CODE_BANK 8'h10
`define BANK_ADDR 18'h0_5555

// status bit positions in a flash read
`define POLL_BIT 7
`define TOGGLE_BIT 6

`define LEN_PROGRAM 3'h4
`define LEN_ERASE 3'h6
`define LEN_ID 3'h3

`endif

/* File: rtl/flash_host_ctrl.sv */
// flash_host_ctrl: host side sequencer driving the flash bank through its strobes.
// assumes dq_in is synchronous to clock and the bench resolves the shared data wire.
`timescale 1ns/1ps
`include "flash_host_consts.svh"

module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter logic [31:0] ERASE_TIMEOUT_CYC = 32'h0BEB_C200
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire req_t req,
	output logic req_ready,
	output logic rsp_done,
	output rsp_t rsp,
	output flash_pins_t pins,
	input wire logic [7:0] dq_in
);

	typedef enum logic [7:0] {
		S_IDLE = 8'b0000_0001,
		S_WSET = 8'b0000_0010,
		S_WLOW = 8'b0000_0100,
		S_WHIGH = 8'b0000_1000,
		S_RD = 8'b0001_0000,
		S_RGAP = 8'b0010_0000,
		S_SETTLE = 8'b0100_0000,
		S_FIN = 8'b1000_0000
	} state_t;

	typedef struct packed {
		state_t state;
		req_t cur;
		logic [2:0] step;
		logic [15:0] cnt;
		logic [31:0] tmo;
		logic polling;
		logic first;
		logic last_tog;
		logic [1:0] stable;
		logic ready;
		logic done;
		rsp_t rsp;
		flash_pins_t pins;
	} st_t;

	localparam flash_pins_t PINS_IDLE = '{addr: 18'h0_0000, dq_out: 8'h00, dq_oe_n: 1'b1,
		flash_bank_select_n: 1'b1, sram_bank_select_n: 1'b1, write_strobe_n: 1'b1,
		output_gate_n: 1'b1};
	localparam st_t ST_RST = '{state: S_IDLE, cur: '0, step: 3'h0, cnt: 16'h0000,
		tmo: 32'h0000_0000, polling: 1'b0, first: 1'b0, last_tog: 1'b0, stable: 2'h0,
		ready: 1'b1, done: 1'b0, rsp: '0, pins: PINS_IDLE};

	// address and data for one write of a command sequence
	function automatic logic [25:0] seq_word(input op_t op, input logic [2:0] step,
		input logic [17:0] a, input logic [7:0] d);
		logic [7:0] c;
		c = `CODE_ERASE_SETUP;
		case (op)
			OP_PROGRAM: c = `CODE_PROGRAM;
			OP_ID_ENTRY: c = `CODE_ID_ENTRY;
			OP_ID_EXIT: c = `CODE_ID_EXIT;
			default: c = `CODE_ERASE_SETUP;
		endcase
		case (step)
			3'h0: seq_word = {`UNL_ADDR0, `UNL_DATA0};
			3'h1: seq_word = {`UNL_ADDR1, `UNL_DATA1};
			3'h2: seq_word = {`UNL_ADDR0, c};
			3'h3: begin
				if (op == OP_PROGRAM) begin
					seq_word = {a, d};
				end else begin
					seq_word = {`UNL_ADDR0, `UNL_DATA0};
				end
			end
			3'h4: seq_word = {`UNL_ADDR1, `UNL_DATA1};
			default: begin
				if (op == OP_SECTOR_ERASE) begin
					seq_word = {a[17:12], 12'h000, `CODE_SECTOR};
				end else begin
					seq_word = {`BANK_ADDR, `CODE_BANK};
				end
			end
		endcase
	endfunction : seq_word

	function automatic logic [2:0] seq_len(input op_t op);
		case (op)
			OP_PROGRAM: seq_len = `LEN_PROGRAM;
			OP_SECTOR_ERASE, OP_BANK_ERASE: seq_len = `LEN_ERASE;
			default: seq_len = `LEN_ID;
		endcase
	endfunction : seq_len

	st_t st_q;
	st_t st_d;

	always_comb begin
		logic [25:0] w;
		logic tog;
		logic poll_ok;
		logic [31:0] limit;
		w = seq_word(st_q.cur.op, st_q.step, st_q.cur.addr, st_q.cur.data);
		tog = st_q.rsp.rdata[`TOGGLE_BIT];
		// program completes when the poll bit shows bit 7 of the true byte, erase when it reads one
		poll_ok = (st_q.cur.op == OP_PROGRAM) ?
			(st_q.rsp.rdata[`POLL_BIT] == st_q.cur.data[`POLL_BIT]) :
			st_q.rsp.rdata[`POLL_BIT];
		limit = (st_q.cur.op == OP_PROGRAM) ? 32'(`PROG_MAX_CYC) : ERASE_TIMEOUT_CYC;
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.pins.sram_bank_select_n = 1'b1; // never contend with the flash select
		if (st_q.polling) begin
			st_d.tmo = st_q.tmo + 32'h0000_0001;
		end
		case (st_q.state)
			S_IDLE: begin
				if (req_valid) begin
					st_d.cur = req;
					st_d.step = 3'h0;
					st_d.cnt = 16'h0000;
					st_d.rsp = '0;
					st_d.polling = 1'b0;
					if (req.op == OP_READ) begin
						st_d.pins.addr = req.addr;
						st_d.state = S_RD;
					end else begin
						// program target must already be erased; no read-back here
						st_d.state = S_WSET;
					end
				end
			end
			S_WSET: begin
				// address and data settle before the strobe falls
				st_d.pins.addr = w[25:8];
				st_d.pins.dq_out = w[7:0];
				st_d.pins.dq_oe_n = 1'b0;
				st_d.pins.output_gate_n = 1'b1;
				st_d.pins.flash_bank_select_n = 1'b0;
				st_d.cnt = 16'h0000;
				st_d.state = S_WLOW;
			end
			S_WLOW: begin
				st_d.pins.write_strobe_n = 1'b0; // strobe falls last: address latch
				st_d.cnt = st_q.cnt + 16'h0001;
				if (st_q.cnt == 16'(`WE_LOW_CYC)) begin
					st_d.pins.write_strobe_n = 1'b1; // pulse far above 5 ns
					st_d.state = S_WHIGH;
				end
			end
			S_WHIGH: begin
				// bank select and data held one cycle past the strobe rise
				st_d.pins.flash_bank_select_n = 1'b1;
				st_d.pins.dq_oe_n = 1'b1;
				st_d.step = st_q.step + 3'h1;
				st_d.cnt = 16'h0000;
				if (st_q.step + 3'h1 != seq_len(st_q.cur.op)) begin
					st_d.state = S_WSET;
				end else if (st_q.cur.op == OP_PROGRAM || st_q.cur.op == OP_SECTOR_ERASE ||
					st_q.cur.op == OP_BANK_ERASE) begin
					// status polling starts right after the last rising strobe
					st_d.polling = 1'b1;
					st_d.first = 1'b1;
					st_d.stable = 2'h0;
					st_d.tmo = 32'h0000_0000;
					st_d.pins.addr = (st_q.cur.op == OP_PROGRAM) ? st_q.cur.addr : w[25:8];
					st_d.state = S_RD;
				end else begin
					st_d.state = S_FIN; // id entry or exit
				end
			end
			S_RD: begin
				st_d.pins.flash_bank_select_n = 1'b0;
				st_d.pins.output_gate_n = 1'b0;
				st_d.pins.dq_oe_n = 1'b1;
				st_d.cnt = st_q.cnt + 16'h0001;
				if (st_q.cnt == 16'(`RD_CYC)) begin
					st_d.rsp.rdata = dq_in; // status only while busy
					st_d.pins.flash_bank_select_n = 1'b1;
					st_d.pins.output_gate_n = 1'b1;
					st_d.state = S_RGAP;
				end
			end
			S_RGAP: begin
				st_d.cnt = 16'h0000;
				if (!st_q.polling) begin
					st_d.state = S_FIN;
				end else begin
					st_d.first = 1'b0;
					st_d.last_tog = tog;
					// toggle unchanged over three reads in a row and poll bit agrees on the last two
					if (!st_q.first && tog == st_q.last_tog && poll_ok) begin
						st_d.stable = st_q.stable + 2'h1;
					end else begin
						st_d.stable = 2'h0;
					end
					if (!st_q.first && tog == st_q.last_tog && poll_ok &&
						st_q.stable + 2'h1 == `STABLE_NEED) begin
						st_d.polling = 1'b0;
						st_d.state = (st_q.cur.op == OP_PROGRAM) ? S_SETTLE : S_FIN;
					end else if (st_q.tmo >= limit) begin
						// device stuck or sequence rejected; report and give up
						st_d.polling = 1'b0;
						st_d.rsp.err = 1'b1;
						st_d.state = S_FIN;
					end else begin
						st_d.state = S_RD;
					end
				end
			end
			S_SETTLE: begin
				// next array read only after the data bus is valid again
				st_d.cnt = st_q.cnt + 16'h0001;
				if (st_q.cnt == 16'(`SETTLE_CYC)) begin
					st_d.state = S_FIN;
				end
			end
			S_FIN: begin
				st_d.done = 1'b1;
				st_d.state = S_IDLE;
			end
			default: begin
				st_d = ST_RST;
			end
		endcase
		st_d.ready = (st_d.state == S_IDLE);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign req_ready = st_q.ready;
	assign rsp_done = st_q.done;
	assign rsp = st_q.rsp;
	assign pins = st_q.pins;

endmodule : flash_host_ctrl

/* File: rtl/flash_host_pkg.sv */
// flash_host_pkg: types shared by the flash host and its bench.
// assumes the constants header sits beside it.
package flash_host_pkg;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_SECTOR_ERASE = 3'h2,
		OP_BANK_ERASE = 3'h3,
		OP_ID_ENTRY = 3'h4,
		OP_ID_EXIT = 3'h5
	} op_t;

	typedef struct packed {
		op_t op;
		logic [17:0] addr;
		logic [7:0] data;
	} req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic err;
	} rsp_t;

	typedef struct packed {
		logic [17:0] addr;
		logic [7:0] dq_out;
		logic dq_oe_n;
		logic flash_bank_select_n;
		logic sram_bank_select_n;
		logic write_strobe_n;
		logic output_gate_n;
	} flash_pins_t;

endpackage : flash_host_pkg
